// ---- rtl/compat_trace_cfg.svh ----
`ifndef COMPAT_TRACE_CFG_SVH
`define COMPAT_TRACE_CFG_SVH

// Bit positions inside the stacked status longword.
`define FRAME_CM_BIT      31
`define FRAME_TP_BIT      30
`define FRAME_IS_BIT      26
`define FRAME_IPL_LSB     16
`define FRAME_T_BIT       4
`define FRAME_CC_LSB      0

// Values forced into the stacked status longword on a trace fault.
`define FRAME_IPL_VALUE   5'h00
`define FRAME_IS_VALUE    1'b0
`define FRAME_CM_VALUE    1'b1

// Shared trace-fault vector offset, same as the native one.
`define TRACE_VECTOR      16'h0028

// Status word bits visible to compatibility code.
`define PSW_VISIBLE_MASK  16'h001f

// Reset values.
`define RESET_WORD        32'h00000000
`define RESET_HALF        16'h0000

`endif

// ---- rtl/compat_trace_pkg.sv ----
package compat_trace_pkg;

  typedef struct packed {
    logic       compat;
    logic       tracePend;
    logic       onIntStack;
    logic [4:0] interrupt_priority_level;
    logic       trace;
    logic [3:0] cc;
  } psl_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PSL  = 2'b01,
    ST_PC   = 2'b10,
    ST_VEC  = 2'b11
  } trap_state_t;

endpackage

// ---- rtl/compat_mode_trace_trap_unit.sv ----
// What this block does
// RL1: Trace fault when trace set at prior start.
// RL2: Push two longwords: status then program counter.
// RL3: Stacked level and stack flag zero, compat one.
// RL4: Use the native trace-fault vector.
// RL5: Odd fetch abort beats the trace fault.
// RL6: Compat returns with stacked trace arm one-instruction trace.
// RL7: Exception return with trace, compat, no pending arms trace.
// RL8: No stack overflow trap in compat mode.
// RL9: No double-error trap in compat mode.
// RL10: Power, parity, memory-management traps enter native mode.
// RL11: I/O space references are flagged, results undefined.
// RL12: Only part of status word visible, via few insns.
// RL13: Interlock modify cycles to I/O registers, never memory.
// RL14: Freshly written code flushes prefetch, no sync needed.
// RL15: Trace sampled into pending state, consumed at fault.
`timescale 1ns/100ps
`include "compat_trace_cfg.svh"

module compat_mode_trace_trap_unit (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     insnStart,
  input  wire logic [31:0]              pcIn,
  input  wire compat_trace_pkg::psl_t   processor_status_longword,
  input  wire logic [15:0]              pswWordIn,
  input  wire logic                     retCompat,
  input  wire logic                     retStackedTrace,
  input  wire logic                     excReturn,
  input  wire compat_trace_pkg::psl_t   excReturnPsl,
  input  wire logic                     oddFetchAbort,
  input  wire logic                     powerFail,
  input  wire logic                     memParity,
  input  wire logic                     memMgmt,
  input  wire logic                     ioRef,
  input  wire logic                     ccInsn,
  input  wire logic                     rmwRead,
  input  wire logic                     rmwTargetIo,
  input  wire logic                     rmwWrite,
  input  wire logic                     insnWrite,
  output logic                          traceFault,
  output logic                          pushValid,
  output logic [31:0]                   pushData,
  output logic                          vectorValid,
  output logic [15:0]                   vectorOffset,
  output logic                          enterNative,
  output logic                          ioUnpredictable,
  output logic                          busLock,
  output logic                          prefetchFlush,
  output logic [15:0]                   pswVisible,
  output logic                          tracePending,
  output logic                          busy
);
  import compat_trace_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Builds the status longword stacked on a trace fault.
  function automatic logic [31:0] buildFrame(input psl_t p);
    logic [31:0] w;
    w = `RESET_WORD;
    w[`FRAME_CM_BIT] = `FRAME_CM_VALUE; // RL3
    w[`FRAME_TP_BIT] = 1'b0;
    w[`FRAME_IS_BIT] = `FRAME_IS_VALUE; // RL3
    w[`FRAME_IPL_LSB +: 5] = `FRAME_IPL_VALUE; // RL3
    w[`FRAME_T_BIT] = p.trace;
    w[`FRAME_CC_LSB +: 4] = p.cc;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  trap_state_t state;
  trap_state_t next_state;
  logic        armed;
  logic        next_armed;
  logic [31:0] savedPsl;
  logic [31:0] next_savedPsl;
  logic [31:0] savedPc;
  logic [31:0] next_savedPc;
  logic        next_traceFault;
  logic        next_pushValid;
  logic [31:0] next_pushData;
  logic        next_vectorValid;
  logic [15:0] next_vectorOffset;
  logic        next_enterNative;
  logic        next_ioUnpredictable;
  logic        next_busLock;
  logic        next_prefetchFlush;
  logic [15:0] next_pswVisible;
  logic        next_tracePending;
  logic        next_busy;

  always_comb begin
    next_state           = state;
    next_armed           = armed;
    next_savedPsl        = savedPsl;
    next_savedPc         = savedPc;
    next_traceFault      = 1'b0;
    next_pushValid       = 1'b0;
    next_pushData        = `RESET_WORD;
    next_vectorValid     = 1'b0;
    next_vectorOffset    = vectorOffset;
    next_enterNative     = 1'b0;
    next_ioUnpredictable = 1'b0;
    next_busLock         = busLock;
    next_prefetchFlush   = 1'b0;
    next_pswVisible      = pswVisible;
    next_tracePending    = tracePending;
    next_busy            = (state != ST_IDLE);

    // Compat returns with a stacked trace bit, and exception returns with trace and compat set and no trace pending, arm tracing of one instruction.
    if (processor_status_longword.compat && retCompat && retStackedTrace) begin
      next_armed = 1'b1; // RL6
    end
    if (excReturn && excReturnPsl.trace && excReturnPsl.compat && !excReturnPsl.tracePend) begin
      next_armed = 1'b1; // RL7
    end

    case (state)
      ST_IDLE: begin
        if (insnStart) begin
          if (oddFetchAbort) begin
            next_tracePending = 1'b0; // RL5
            next_armed        = 1'b0;
            next_enterNative  = 1'b1;
          end else if (tracePending) begin
            next_traceFault   = 1'b1; // RL1
            next_tracePending = 1'b0; // RL15
            next_savedPsl     = buildFrame(processor_status_longword);
            next_savedPc      = pcIn;
            next_enterNative  = 1'b1;
            next_busy         = 1'b1;
            next_state        = ST_PSL;
          end else begin
            next_tracePending = processor_status_longword.trace | armed; // RL15
            next_armed        = 1'b0;
          end
        end
      end
      ST_PSL: begin
        next_pushValid = 1'b1; // RL2
        next_pushData  = savedPsl;
        next_busy      = 1'b1;
        next_state     = ST_PC;
      end
      ST_PC: begin
        next_pushValid = 1'b1; // RL2
        next_pushData  = savedPc;
        next_busy      = 1'b1;
        next_state     = ST_VEC;
      end
      ST_VEC: begin
        next_vectorValid  = 1'b1;
        next_vectorOffset = `TRACE_VECTOR; // RL4
        next_busy         = 1'b0;
        next_state        = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // Stack overflow and double errors raise nothing here; a power-fail, parity or
    // memory-management error in compat mode forces the native-mode switch below.
    if (processor_status_longword.compat && (powerFail || memParity || memMgmt)) begin
      next_enterNative = 1'b1; // RL10 RL9 RL8
    end

    if (processor_status_longword.compat && ioRef) begin
      next_ioUnpredictable = 1'b1; // RL11
    end

    if (processor_status_longword.compat && (ccInsn || retCompat)) begin
      next_pswVisible = pswWordIn & `PSW_VISIBLE_MASK; // RL12
    end else if (!processor_status_longword.compat) begin
      next_pswVisible = `RESET_HALF; // RL12
    end

    // Lock is held from the modify read to its write, only for I/O registers.
    if (rmwWrite) begin
      next_busLock = 1'b0; // RL13
    end
    if (processor_status_longword.compat && rmwRead && rmwTargetIo) begin
      next_busLock = 1'b1; // RL13
    end

    if (processor_status_longword.compat && insnWrite) begin
      next_prefetchFlush = 1'b1; // RL14
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state           <= ST_IDLE;
      armed           <= 1'b0;
      savedPsl        <= `RESET_WORD;
      savedPc         <= `RESET_WORD;
      traceFault      <= 1'b0;
      pushValid       <= 1'b0;
      pushData        <= `RESET_WORD;
      vectorValid     <= 1'b0;
      vectorOffset    <= `RESET_HALF;
      enterNative     <= 1'b0;
      ioUnpredictable <= 1'b0;
      busLock         <= 1'b0;
      prefetchFlush   <= 1'b0;
      pswVisible      <= `RESET_HALF;
      tracePending    <= 1'b0;
      busy            <= 1'b0;
    end else begin
      state           <= next_state;
      armed           <= next_armed;
      savedPsl        <= next_savedPsl;
      savedPc         <= next_savedPc;
      traceFault      <= next_traceFault;
      pushValid       <= next_pushValid;
      pushData        <= next_pushData;
      vectorValid     <= next_vectorValid;
      vectorOffset    <= next_vectorOffset;
      enterNative     <= next_enterNative;
      ioUnpredictable <= next_ioUnpredictable;
      busLock         <= next_busLock;
      prefetchFlush   <= next_prefetchFlush;
      pswVisible      <= next_pswVisible;
      tracePending    <= next_tracePending;
      busy            <= next_busy;
    end
  end

endmodule

// ---- tb/compat_trace_checker_assertions.sv ----
`timescale 1ns/100ps
module compat_trace_checker
  import compat_trace_pkg::*;
(
  input logic                   ref_clk,
  input logic                   rst,
  input logic                   insnStart,
  input logic                   oddFetchAbort,
  input logic                   rmwRead,
  input logic                   rmwTargetIo,
  input compat_trace_pkg::psl_t processor_status_longword,
  input logic                   traceFault,
  input logic                   pushValid,
  input logic [31:0]            pushData,
  input logic                   vectorValid,
  input logic [15:0]            vectorOffset,
  input logic                   enterNative,
  input logic                   busLock,
  input logic                   tracePending,
  input logic                   busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  fault_cause_a: assert property (traceFault |-> $past(insnStart && tracePending))
    else $error("fault without pending trace");
  fault_frame_a: assert property (traceFault |=> pushValid ##1 pushValid ##1 vectorValid)
    else $error("frame push sequence broken");
  frame_status_a: assert property (traceFault |=> pushData[31] && pushData[30:16] == 15'h0)
    else $error("stacked status bits wrong");
  vector_shared_a: assert property (vectorValid |-> vectorOffset == 16'h0028)
    else $error("wrong trace vector");
  odd_abort_a: assert property (insnStart && oddFetchAbort && !busy |=> !traceFault && enterNative)
    else $error("odd fetch abort lost");
  pend_consumed_a: assert property (traceFault |-> !tracePending)
    else $error("pending not consumed");
  busy_span_a: assert property (traceFault |-> busy [*3] ##1 !busy)
    else $error("busy span wrong");
  io_lock_a: assert property (rmwRead && rmwTargetIo && processor_status_longword.compat |=> busLock)
    else $error("device register not locked");
  mem_nolock_a: assert property (rmwRead && !rmwTargetIo && !busLock |=> !busLock)
    else $error("memory modify locked");
  cover property (traceFault);
  cover property (insnStart && oddFetchAbort);
  cover property (busLock);
endmodule
bind compat_mode_trace_trap_unit compat_trace_checker chk (.*);

// ---- tb/compat_mode_trace_trap_unit_bench.sv ----
`timescale 1ns/100ps
module compat_mode_trace_trap_unit_bench;
  import compat_trace_pkg::*;
  logic ref_clk = 0, rst = 1, insnStart = 0, retCompat = 0, retStackedTrace = 0, excReturn = 0;
  logic oddFetchAbort = 0, powerFail = 0, memParity = 0, memMgmt = 0, ioRef = 0, ccInsn = 0;
  logic rmwRead = 0, rmwTargetIo = 0, rmwWrite = 0, insnWrite = 0;
  logic traceFault, pushValid, vectorValid, enterNative, ioUnpredictable, busLock;
  logic prefetchFlush, tracePending, busy;
  logic [31:0] pcIn = 0, pushData, p;
  logic [15:0] pswWordIn = 0, vectorOffset, pswVisible;
  psl_t        processor_status_longword = '0, excReturnPsl = '0;
  int          n_mismatch = 0, checks_done = 0, cyc = 0;
  compat_mode_trace_trap_unit dut (.*);
  ////////////////////////////////////////////////////////////////////////////
  initial forever #5 ref_clk = ~ref_clk;
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [31:0] frame(psl_t s);
    return {1'b1, 26'h0, s.trace, s.cc};
  endfunction
  task automatic bound(logic [31:0] pc, logic odd);
    insnStart = 1;
    pcIn = pc;
    oddFetchAbort = odd;
    step();
    insnStart = 0;
    oddFetchAbort = 0;
  endtask
  task automatic fault(logic [31:0] pc, logic t);
    bound(pc, 0);
    chk(traceFault, t);
    if (t) begin
      chk(tracePending, 0);
      chk(busy, 1);
      step();
      chk(pushValid, 1);
      chk(pushData, frame(processor_status_longword));
      step();
      chk(pushValid, 1);
      chk(pushData, pc);
      step();
      chk(vectorValid, 1);
      chk(vectorOffset, 16'h0028);
      chk(busy, 0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h19cb7578));
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 0;
    chk(busy, 0);
    processor_status_longword.compat = 1;
    repeat (20) begin
      {processor_status_longword.trace, processor_status_longword.cc} = 5'($urandom);
      p = $urandom;
      bound(p, 0);
      chk(tracePending, processor_status_longword.trace);
      p = p + 2;
      fault(p, processor_status_longword.trace);
      processor_status_longword.trace = 0;
    end
    processor_status_longword.trace = 1;
    bound(p, 0);
    processor_status_longword.trace = 0;
    bound(p, 1);
    chk(traceFault, 0);
    chk(enterNative, 1);
    chk(tracePending, 0);
    fault(p, 0);
    for (int s = 0; s < 2; s++) begin
      retCompat = 1;
      retStackedTrace = s[0];
      step();
      retCompat = 0;
      fault(p, 0);
      fault(p, s[0]);
    end
    excReturnPsl.compat = 1;
    excReturnPsl.trace = 1;
    excReturn = 1;
    step();
    excReturn = 0;
    fault(p, 0);
    fault(p, 1);
    for (int c = 1; c >= 0; c--) begin
      processor_status_longword.compat = c[0];
      for (int i = 0; i < 3; i++) begin
        {powerFail, memParity, memMgmt} = 3'h4 >> i;
        step();
        {powerFail, memParity, memMgmt} = 3'h0;
        chk(enterNative, c);
      end
      {ioRef, insnWrite, ccInsn} = 3'h7;
      pswWordIn = $urandom;
      step();
      {ioRef, insnWrite, ccInsn} = 3'h0;
      chk(ioUnpredictable, c);
      chk(prefetchFlush, c);
      chk(pswVisible, c ? pswWordIn & 16'h001f : 16'h0000);
      rmwRead = 1;
      rmwTargetIo = $urandom;
      step();
      rmwRead = 0;
      chk(busLock, rmwTargetIo & c[0]);
      rmwWrite = 1;
      step();
      rmwWrite = 0;
      step();
      chk(busLock, 0);
    end
    give_verdict();
  end
endmodule
